//--- gdp_pkg.sv
// Constants, field layouts and carrier types of the gate driver protection
package gdp_pkg;

  // ==========================================================================
  // Register bus geometry
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 8;
  localparam logic [7:0]  OFS_ERROR        = 8'h00;
  localparam logic [7:0]  OFS_CONTROL      = 8'h04;
  localparam logic [7:0]  OFS_STATUS       = 8'h08;
  localparam logic [7:0]  OFS_TURNON_TIME  = 8'h0C;
  localparam logic [7:0]  OFS_TURNOFF_TIME = 8'h10;

  // ==========================================================================
  // Error register fields (write one to clear)
  localparam int          ERR_SHOOT_BIT    = 0;
  localparam int          ERR_GATE_BIT     = 1;
  localparam int          ERR_OVERTEMP_BIT = 2;
  localparam int          ERR_SERIAL_BIT   = 3;

  // Control register fields
  localparam int          CTL_PARITY_BIT   = 0;
  localparam int          CTL_CAPTURE_BIT  = 1;
  localparam logic        PARITY_EN_RESET  = 1'b1;

  // Status register fields
  localparam int          STS_SHOOT_BIT    = 0;
  localparam int          STS_ON_ARM_BIT   = 1;
  localparam int          STS_OFF_ARM_BIT  = 2;
  localparam int          STS_GATE_ON_BIT  = 3;
  localparam int          STS_INHIBIT_BIT  = 4;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS    = 50;
  localparam int          GLITCH_NS        = 50;
  localparam int          GLITCH_CYCLES    =
    ((GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          DEAD_TIME_NS     = 200;
  localparam int          DEAD_CYCLES      =
    ((DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  TIME_OVERFLOW    = 8'hFF;
  localparam logic [7:0]  TIME_RESET       = 8'h00;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gdp_bus_t;

  typedef struct packed {
    logic strobe;
    logic format_ok;
    logic parity_ok;
  } gdp_cmd_t;

  typedef struct packed {
    logic gate_high_threshold;
    logic gate_low_threshold;
    logic hard_transition;
    logic secondary_capture_clock;
  } gdp_gate_t;

  typedef struct packed {
    logic       running;
    logic [7:0] count;
  } gdp_timer_t;

endpackage

//--- gdp_monitor.sv
// Shoot-through guard, gate monitoring, error flags and low-supply notify
//
// Behaviour
// - Counterpart on inhibits own PWM input
// - PWM high while inhibited ignored, sets error
// - A conflict sampled at a single clock edge already sets error
// - Fixed dead time after counterpart turns off
// - Readable shoot-through status shows detected conflict
// - Guard cannot be disabled; ground counterpart disables
// - Turn-on 8-bit timeout, overflow sets gate error
// - Turn-off timeout from hard transition, overflow errors
// - Test modes skip turn-on timeout, keep turn-off
// - Capture trigger arms both capture-armed bits
// - Armed turn-on stores gate time or FF
// - Armed turn-off stores gate time or FF
// - Over-temperature sets warning flag only
// - Invalid serial command sets serial error flag
// - Parity check selectable by host
// - Notify low while supply low or invalid
`timescale 1ns/1ps

module gdp_monitor
  import gdp_pkg::*;
#(
  parameter int DEAD_TIME_CYCLES = gdp_pkg::DEAD_CYCLES,
  parameter int FILTER_CYCLES    = gdp_pkg::GLITCH_CYCLES
) (
  input  wire logic                  MCLK_IN,
  input  wire logic                  RSTN_IN,
  input  wire logic                  PWM_INPUT_IN,
  input  wire logic                  COUNTERPART_PWM_INPUT_IN,
  input  wire gdp_pkg::gdp_gate_t    GATE_IN,
  input  wire logic                  VERIFICATION_MODE_IN,
  input  wire logic                  WEAK_ON_MODE_IN,
  input  wire logic                  OVERTEMP_IN,
  input  wire gdp_pkg::gdp_cmd_t     CMD_IN,
  input  wire logic                  SECONDARY_UNDERVOLTAGE_IN,
  input  wire logic                  DIGITAL_SUPPLY_OK_IN,
  input  wire gdp_pkg::gdp_bus_t     BUS_IN,
  output logic [gdp_pkg::DATA_W-1:0] RDATA_OUT,
  output logic                       GATE_ON_OUT,
  output logic                       LOW_SUPPLY_NOTIFY_N_OUT,
  output logic                       LOW_SUPPLY_NOTIFY_N_OE_OUT
);

  // ==========================================================================
  // State
  typedef struct packed {
    // Shoot-through guard and own output
    logic              gate_on;
    logic              gate_on_prev;
    logic [7:0]        dead_cnt;
    logic [3:0]        filt_cnt;
    logic              ignore_hold;
    logic              shoot_status;
    // Sticky error flags, cleared only by a write of one
    logic              err_shoot;
    logic              err_gate;
    logic              err_overtemp;
    logic              err_serial;
    // Serial check and gate monitoring
    logic              parity_en;
    logic              on_armed;
    logic              off_armed;
    gdp_timer_t        to_on;
    gdp_timer_t        to_off;
    gdp_timer_t        cap_on;
    gdp_timer_t        cap_off;
    logic [7:0]        turnon_gate_time;
    logic [7:0]        turnoff_gate_time;
    // Supply notify and registered read data
    logic              notify_drive;
    logic [DATA_W-1:0] rdata;
  } gdp_state_t;

  // Loads are cut to counter width on purpose; the defaults fit easily
  localparam logic [7:0] DEAD_LOAD = 8'(DEAD_TIME_CYCLES);
  localparam logic [3:0] FILT_LOAD = 4'(FILTER_CYCLES);

  gdp_state_t st;
  gdp_state_t next_st;

  // Decodes shared between sections of the next-state logic
  logic inhibit;
  logic conflict;
  logic turn_on_start;
  logic tick;
  logic err_wr;
  logic ctl_wr;
  logic set_shoot;
  logic set_gate;
  logic set_serial;
  logic on_timeout_en;

  // ==========================================================================
  // Combinational next state
  always_comb begin
    next_st = st;
    tick = GATE_IN.secondary_capture_clock;
    set_gate = 1'b0;
    set_shoot = 1'b0;
    set_serial = 1'b0;

    // --------------------------------------------------------------------
    // Shoot-through guard. No bit turns it off: only a counterpart held
    // low keeps inhibit away for good.
    // Dead time runs from the first edge that sees the counterpart off;
    // a shorter gap from the host is refused, not stretched.
    if (COUNTERPART_PWM_INPUT_IN) begin
      next_st.dead_cnt = DEAD_LOAD;
    end else if (st.dead_cnt != 8'h00) begin
      next_st.dead_cnt = st.dead_cnt - 8'h01;
    end
    inhibit = COUNTERPART_PWM_INPUT_IN || (st.dead_cnt != 8'h00);
    conflict = PWM_INPUT_IN && inhibit;

    // A request seen while inhibited stays ignored until PWM drops, so the
    // output never turns on mid-pulse once the dead time runs out.
    if (!PWM_INPUT_IN) begin
      next_st.ignore_hold = 1'b0;
    end else if (conflict) begin
      next_st.ignore_hold = 1'b1;
    end

    // Glitch filter: the conflict must persist before it counts
    // With a one-cycle filter a single sampled conflict is enough
    if (!conflict) begin
      next_st.filt_cnt = 4'h0;
    end else if (st.filt_cnt < FILT_LOAD) begin
      next_st.filt_cnt = st.filt_cnt + 4'h1;
    end
    set_shoot = conflict && (st.filt_cnt == FILT_LOAD - 4'h1);
    next_st.shoot_status = conflict &&
                           (st.filt_cnt >= FILT_LOAD - 4'h1);

    next_st.gate_on = PWM_INPUT_IN && !inhibit && !st.ignore_hold &&
                      !(PWM_INPUT_IN && conflict);
    next_st.gate_on_prev = st.gate_on;
    turn_on_start = st.gate_on && !st.gate_on_prev;

    // --------------------------------------------------------------------
    // Gate timeout, turn-on edge. Counting is on the secondary tick.
    // Overflow is the tick that finds FF, so 256 ticks without the
    // threshold already count as a failure.
    on_timeout_en = !VERIFICATION_MODE_IN && !WEAK_ON_MODE_IN;
    if (turn_on_start) begin
      next_st.to_on.running = on_timeout_en;
      next_st.to_on.count = 8'h00;
    end else if (st.to_on.running) begin
      if (!on_timeout_en) begin
        // A test mode entered mid-sequence drops the check at once
        next_st.to_on.running = 1'b0;
      end else if (GATE_IN.gate_high_threshold) begin
        next_st.to_on.running = 1'b0;
      end else if (tick) begin
        if (st.to_on.count == TIME_OVERFLOW) begin
          next_st.to_on.running = 1'b0;
          set_gate = 1'b1;
        end else begin
          next_st.to_on.count = st.to_on.count + 8'h01;
        end
      end
    end

    // Gate timeout, turn-off hard transition. Active in every mode.
    if (GATE_IN.hard_transition) begin
      next_st.to_off.running = 1'b1;
      next_st.to_off.count = 8'h00;
    end else if (st.to_off.running) begin
      if (GATE_IN.gate_low_threshold) begin
        next_st.to_off.running = 1'b0;
      end else if (tick) begin
        if (st.to_off.count == TIME_OVERFLOW) begin
          next_st.to_off.running = 1'b0;
          set_gate = 1'b1;
        end else begin
          next_st.to_off.count = st.to_off.count + 8'h01;
        end
      end
    end

    // --------------------------------------------------------------------
    // Timing capture on its own counters, so arming cannot disturb the
    // timeout running on the same edge.
    // Overflow still clears the armed bit, so software sees the capture
    // finished and reads FF.
    if (turn_on_start && st.on_armed) begin
      next_st.cap_on.running = 1'b1;
      next_st.cap_on.count = 8'h00;
      next_st.turnon_gate_time = TIME_RESET;
    end else if (st.cap_on.running) begin
      if (GATE_IN.gate_high_threshold) begin
        next_st.cap_on.running = 1'b0;
        next_st.turnon_gate_time = st.cap_on.count;
        next_st.on_armed = 1'b0;
      end else if (tick) begin
        if (st.cap_on.count == TIME_OVERFLOW) begin
          next_st.cap_on.running = 1'b0;
          next_st.turnon_gate_time = TIME_OVERFLOW;
          next_st.on_armed = 1'b0;
        end else begin
          next_st.cap_on.count = st.cap_on.count + 8'h01;
        end
      end
    end

    if (GATE_IN.hard_transition && st.off_armed) begin
      next_st.cap_off.running = 1'b1;
      next_st.cap_off.count = 8'h00;
      next_st.turnoff_gate_time = TIME_RESET;
    end else if (st.cap_off.running) begin
      if (GATE_IN.gate_low_threshold) begin
        next_st.cap_off.running = 1'b0;
        next_st.turnoff_gate_time = st.cap_off.count;
        next_st.off_armed = 1'b0;
      end else if (tick) begin
        if (st.cap_off.count == TIME_OVERFLOW) begin
          next_st.cap_off.running = 1'b0;
          next_st.turnoff_gate_time = TIME_OVERFLOW;
          next_st.off_armed = 1'b0;
        end else begin
          next_st.cap_off.count = st.cap_off.count + 8'h01;
        end
      end
    end

    // --------------------------------------------------------------------
    // Serial command check
    // A bad format always counts; parity only while the host enables it
    set_serial = CMD_IN.strobe &&
                 (!CMD_IN.format_ok ||
                  (st.parity_en && !CMD_IN.parity_ok));

    // --------------------------------------------------------------------
    // Register writes
    // The capture trigger arms and is not stored: control reads back
    // only the parity enable.
    err_wr = BUS_IN.wr && (BUS_IN.addr == OFS_ERROR);
    ctl_wr = BUS_IN.wr && (BUS_IN.addr == OFS_CONTROL);

    if (ctl_wr) begin
      next_st.parity_en = BUS_IN.wdata[CTL_PARITY_BIT];
      if (BUS_IN.wdata[CTL_CAPTURE_BIT]) begin
        next_st.on_armed = 1'b1;
        next_st.off_armed = 1'b1;
      end
    end

    // Flags: a set in the clearing cycle wins
    if (err_wr && BUS_IN.wdata[ERR_SHOOT_BIT]) begin
      next_st.err_shoot = 1'b0;
    end
    if (err_wr && BUS_IN.wdata[ERR_GATE_BIT]) begin
      next_st.err_gate = 1'b0;
    end
    if (err_wr && BUS_IN.wdata[ERR_OVERTEMP_BIT]) begin
      next_st.err_overtemp = 1'b0;
    end
    if (err_wr && BUS_IN.wdata[ERR_SERIAL_BIT]) begin
      next_st.err_serial = 1'b0;
    end

    // Sets come last so an event in the clearing cycle keeps its flag
    if (set_shoot) begin
      next_st.err_shoot = 1'b1;
    end
    if (set_gate) begin
      next_st.err_gate = 1'b1;
    end
    if (OVERTEMP_IN) begin
      next_st.err_overtemp = 1'b1;
    end
    if (set_serial) begin
      next_st.err_serial = 1'b1;
    end

    // --------------------------------------------------------------------
    // Low-supply notify: open drain, driven low while the fault lasts
    next_st.notify_drive = SECONDARY_UNDERVOLTAGE_IN ||
                           !DIGITAL_SUPPLY_OK_IN;

    // --------------------------------------------------------------------
    // Register reads, answered in the next cycle only
    // Unmapped addresses read zero, so probing them is harmless
    next_st.rdata = '0;
    if (BUS_IN.rd) begin
      case (BUS_IN.addr)
        OFS_ERROR: begin
          next_st.rdata[ERR_SHOOT_BIT] = st.err_shoot;
          next_st.rdata[ERR_GATE_BIT] = st.err_gate;
          next_st.rdata[ERR_OVERTEMP_BIT] = st.err_overtemp;
          next_st.rdata[ERR_SERIAL_BIT] = st.err_serial;
        end
        OFS_CONTROL: begin
          next_st.rdata[CTL_PARITY_BIT] = st.parity_en;
        end
        OFS_STATUS: begin
          next_st.rdata[STS_SHOOT_BIT] = st.shoot_status;
          next_st.rdata[STS_ON_ARM_BIT] = st.on_armed;
          next_st.rdata[STS_OFF_ARM_BIT] = st.off_armed;
          next_st.rdata[STS_GATE_ON_BIT] = st.gate_on;
          next_st.rdata[STS_INHIBIT_BIT] = inhibit;
        end
        OFS_TURNON_TIME: begin
          next_st.rdata = st.turnon_gate_time;
        end
        OFS_TURNOFF_TIME: begin
          next_st.rdata = st.turnoff_gate_time;
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st <= '0;
      st.parity_en <= PARITY_EN_RESET;
      // Supply is treated as invalid until the first sample after reset
      st.notify_drive <= 1'b1;
      st.turnon_gate_time <= TIME_RESET;
      st.turnoff_gate_time <= TIME_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // Open drain: the data stays low and only the enable moves
  assign RDATA_OUT = st.rdata;
  assign GATE_ON_OUT = st.gate_on;
  assign LOW_SUPPLY_NOTIFY_N_OUT = 1'b0;
  assign LOW_SUPPLY_NOTIFY_N_OE_OUT = st.notify_drive;

endmodule

//--- gdp_check_monitor.sv
// Port-level assertions for the gate driver protection block
`timescale 1ns/1ps
module gdp_check_monitor #(
  parameter int DEAD_TIME_CYCLES = 4
) (
  input logic MCLK_IN,
  input logic RSTN_IN,
  input logic PWM_INPUT_IN,
  input logic COUNTERPART_PWM_INPUT_IN,
  input logic SECONDARY_UNDERVOLTAGE_IN,
  input logic DIGITAL_SUPPLY_OK_IN,
  input logic GATE_ON_OUT,
  input logic LOW_SUPPLY_NOTIFY_N_OUT,
  input logic LOW_SUPPLY_NOTIFY_N_OE_OUT
);
  // ==========================================================
  // Dead time shadow, loaded while the counterpart is on
  int dead;
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) dead <= 0;
    else if (COUNTERPART_PWM_INPUT_IN) dead <= DEAD_TIME_CYCLES;
    else if (dead != 0) dead <= dead - 1;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);
  sequence s_conflict;
    PWM_INPUT_IN && COUNTERPART_PWM_INPUT_IN;
  endsequence
  sequence s_idle_cp;
    !COUNTERPART_PWM_INPUT_IN [*6];
  endsequence
  property p_inhibit;
    COUNTERPART_PWM_INPUT_IN |=> !GATE_ON_OUT;
  endproperty
  property p_cause;
    $rose(GATE_ON_OUT) |->
      $past(PWM_INPUT_IN && !COUNTERPART_PWM_INPUT_IN && dead == 0);
  endproperty
  property p_dead;
    dead != 0 |=> !GATE_ON_OUT;
  endproperty
  property p_hold;
    s_conflict ##1 PWM_INPUT_IN [*6] |-> !GATE_ON_OUT;
  endproperty
  property p_ground;
    s_idle_cp ##0 $rose(PWM_INPUT_IN) |=> GATE_ON_OUT;
  endproperty
  property p_nfy_on;
    SECONDARY_UNDERVOLTAGE_IN || !DIGITAL_SUPPLY_OK_IN
      |=> LOW_SUPPLY_NOTIFY_N_OE_OUT;
  endproperty
  // Reset holds the pin driven, so the releasing edge starts no attempt
  property p_nfy_off;
    RSTN_IN && !SECONDARY_UNDERVOLTAGE_IN && DIGITAL_SUPPLY_OK_IN
      |=> !LOW_SUPPLY_NOTIFY_N_OE_OUT;
  endproperty
  property p_nfy_od;
    LOW_SUPPLY_NOTIFY_N_OE_OUT |-> !LOW_SUPPLY_NOTIFY_N_OUT;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("gate on while counterpart on");
  a_cause: assert property (p_cause)
    else $error("gate rose without clean request");
  a_dead: assert property (p_dead)
    else $error("gate on inside dead time");
  a_hold: assert property (p_hold)
    else $error("ignored request reached gate");
  a_ground: assert property (p_ground)
    else $error("gate blocked with counterpart idle");
  a_nfy_on: assert property (p_nfy_on)
    else $error("notify not driven on supply fault");
  a_nfy_off: assert property (p_nfy_off)
    else $error("notify driven with good supply");
  a_nfy_od: assert property (p_nfy_od)
    else $error("notify data not low");
endmodule

//--- gdp_host.sv
// Host controller model: register bus and serial command delivery
`timescale 1ns/1ps
module gdp_host (
  input  wire logic                         MCLK_IN,
  input  wire logic [gdp_pkg::DATA_W-1:0]   RDATA_IN,
  output gdp_pkg::gdp_bus_t                 BUS_OUT,
  output gdp_pkg::gdp_cmd_t                 CMD_OUT
);
  import gdp_pkg::*;
  initial begin
    BUS_OUT = '0;
    CMD_OUT = '0;
  end
  // ==========================================================
  // Released address and data lines show the inverse, not stale values
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK_IN) BUS_OUT <= '{1'b1, 1'b0, a, d};
    @(posedge MCLK_IN) BUS_OUT <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge MCLK_IN) BUS_OUT <= '{1'b0, 1'b1, a, ~a};
    @(posedge MCLK_IN) BUS_OUT <= '{1'b0, 1'b0, ~a, a};
    // Read data stand only in the cycle after the strobe: take them at
    // the edge that closes that cycle
    @(posedge MCLK_IN) d = RDATA_IN;
  endtask
  // Parity bit sent as given; the device decides whether to check it
  task automatic send_cmd(input logic f, input logic p);
    @(posedge MCLK_IN) CMD_OUT <= '{1'b1, f, p};
    @(posedge MCLK_IN) CMD_OUT <= '{1'b0, ~f, ~p};
  endtask
endmodule

//--- gdp_monitor_test.sv
// Self-checking bench for the gate driver protection block
`timescale 1ns/1ps
module gdp_monitor_test;
  import gdp_pkg::*;
  logic       MCLK_IN = 1'b0;
  logic       RSTN_IN = 1'b0;
  logic       pwm = 1'b0, cp = 1'b0, vm = 1'b0, wom = 1'b0, ot = 1'b0;
  logic       uv = 1'b0, dok = 1'b1;
  gdp_gate_t  gate = '0;
  gdp_bus_t   bus;
  gdp_cmd_t   cmd;
  logic [7:0] rdata, rv;
  logic       gate_on, nfy, nfy_oe;
  int         errors = 0, num_checks = 0, n;
  always #25 MCLK_IN = ~MCLK_IN;
  gdp_monitor DUT (
    .MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN), .PWM_INPUT_IN(pwm),
    .COUNTERPART_PWM_INPUT_IN(cp), .GATE_IN(gate),
    .VERIFICATION_MODE_IN(vm), .WEAK_ON_MODE_IN(wom), .OVERTEMP_IN(ot),
    .CMD_IN(cmd), .SECONDARY_UNDERVOLTAGE_IN(uv),
    .DIGITAL_SUPPLY_OK_IN(dok), .BUS_IN(bus), .RDATA_OUT(rdata),
    .GATE_ON_OUT(gate_on), .LOW_SUPPLY_NOTIFY_N_OUT(nfy),
    .LOW_SUPPLY_NOTIFY_N_OE_OUT(nfy_oe));
  gdp_host u_host (.MCLK_IN(MCLK_IN), .RDATA_IN(rdata), .BUS_OUT(bus),
    .CMD_OUT(cmd));
  // ==========================================================
  // Checking and expectations
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_reg(string what, logic [7:0] a, logic [7:0] exp);
    u_host.bus_read(a, rv);
    check(what, exp, rv);
  endtask
  function automatic logic [7:0] serial_exp(logic f, logic p, logic pe);
    serial_exp = '0;
    serial_exp[ERR_SERIAL_BIT] = !f || (pe && !p);
  endfunction
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Gate feedback stimulus
  task automatic ticks(input int t);
    repeat (t) begin
      @(posedge MCLK_IN) gate.secondary_capture_clock <= 1'b1;
      @(posedge MCLK_IN) gate.secondary_capture_clock <= 1'b0;
    end
  endtask
  task automatic turn_on(input int t, input logic hit);
    @(posedge MCLK_IN) pwm <= 1'b1;
    repeat (4) @(posedge MCLK_IN);
    check("gate output", 8'h01, {7'h0, gate_on});
    ticks(t);
    @(posedge MCLK_IN) gate.gate_high_threshold <= hit;
    repeat (2) @(posedge MCLK_IN);
  endtask
  task automatic turn_off(input int t, input logic hit);
    @(posedge MCLK_IN) begin
      pwm <= 1'b0;
      gate.gate_high_threshold <= 1'b0;
      gate.hard_transition <= 1'b1;
    end
    @(posedge MCLK_IN) gate.hard_transition <= 1'b0;
    ticks(t);
    @(posedge MCLK_IN) gate.gate_low_threshold <= hit;
    @(posedge MCLK_IN) gate.gate_low_threshold <= 1'b0;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h80A5));
    repeat (12) @(posedge MCLK_IN);
    RSTN_IN <= 1'b1;
    check_reg("error", OFS_ERROR, 8'h00);
    check_reg("control", OFS_CONTROL, 8'h01);
    check_reg("status", OFS_STATUS, 8'h00);
    check_reg("unmapped", 8'h14, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK_IN) {uv, dok} <= 2'(i);
      repeat (2) @(posedge MCLK_IN);
      check("notify oe", {7'h0, i[1] | !i[0]}, {7'h0, nfy_oe});
      check("notify data", 8'h00, {7'h0, nfy});
    end
    @(posedge MCLK_IN) {uv, dok} <= 2'b01;
    @(posedge MCLK_IN) {cp, pwm} <= 2'b11;
    repeat (3) @(posedge MCLK_IN);
    check("gate output", 8'h00, {7'h0, gate_on});
    check_reg("status", OFS_STATUS, 8'h11);
    check_reg("error", OFS_ERROR, 8'h01);
    @(posedge MCLK_IN) cp <= 1'b0;
    repeat (8) @(posedge MCLK_IN);
    check("gate output", 8'h00, {7'h0, gate_on});
    check_reg("error", OFS_ERROR, 8'h01);
    u_host.bus_write(OFS_ERROR, 8'h01);
    check_reg("error", OFS_ERROR, 8'h00);
    @(posedge MCLK_IN) pwm <= 1'b0;
    // One cycle short of the dead time must be refused
    for (int k = DEAD_CYCLES - 1; k <= DEAD_CYCLES; k++) begin
      @(posedge MCLK_IN) cp <= 1'b1;
      @(posedge MCLK_IN) cp <= 1'b0;
      repeat (k) @(posedge MCLK_IN);
      pwm <= 1'b1;
      repeat (3) @(posedge MCLK_IN);
      check("gate output", 8'(k == DEAD_CYCLES), {7'h0, gate_on});
      check_reg("error", OFS_ERROR, 8'(k < DEAD_CYCLES));
      u_host.bus_write(OFS_ERROR, 8'h0F);
      @(posedge MCLK_IN) pwm <= 1'b0;
    end
    @(posedge MCLK_IN) ot <= 1'b1;
    @(posedge MCLK_IN) ot <= 1'b0;
    check_reg("error", OFS_ERROR, 8'h04);
    u_host.bus_write(OFS_ERROR, 8'h04);
    for (int i = 0; i < 8; i++) begin
      u_host.bus_write(OFS_CONTROL, {7'h0, i[2]});
      u_host.send_cmd(i[1], i[0]);
      check_reg("error", OFS_ERROR, serial_exp(i[1], i[0], i[2]));
      u_host.bus_write(OFS_ERROR, 8'h08);
    end
    u_host.bus_write(OFS_CONTROL, 8'h03);
    check_reg("status", OFS_STATUS, 8'h06);
    n = 1 + $urandom % 200;
    turn_on(n, 1'b1);
    check_reg("on time", OFS_TURNON_TIME, 8'(n));
    check_reg("status", OFS_STATUS, 8'h0C);
    n = 1 + $urandom % 200;
    turn_off(n, 1'b1);
    check_reg("off time", OFS_TURNOFF_TIME, 8'(n));
    check_reg("status", OFS_STATUS, 8'h00);
    check_reg("error", OFS_ERROR, 8'h00);
    for (int m = 0; m < 3; m++) begin
      @(posedge MCLK_IN) {vm, wom} <= 2'(m);
      u_host.bus_write(OFS_CONTROL, 8'h03);
      turn_on(256, 1'b0);
      check_reg("error", OFS_ERROR, m == 0 ? 8'h02 : 8'h00);
      check_reg("on time", OFS_TURNON_TIME, TIME_OVERFLOW);
      turn_off(256, 1'b0);
      check_reg("error", OFS_ERROR, 8'h02);
      check_reg("off time", OFS_TURNOFF_TIME, TIME_OVERFLOW);
      u_host.bus_write(OFS_ERROR, 8'h02);
    end
    end_of_test;
  end
  // Expected run is about 3400 to 4200 cycles
  initial begin
    repeat (20000) @(posedge MCLK_IN);
    errors++;
    end_of_test;
  end
endmodule
bind gdp_monitor gdp_check_monitor #(
  .DEAD_TIME_CYCLES(DEAD_TIME_CYCLES)
) u_chk (
  .MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN), .PWM_INPUT_IN(PWM_INPUT_IN),
  .COUNTERPART_PWM_INPUT_IN(COUNTERPART_PWM_INPUT_IN),
  .SECONDARY_UNDERVOLTAGE_IN(SECONDARY_UNDERVOLTAGE_IN),
  .DIGITAL_SUPPLY_OK_IN(DIGITAL_SUPPLY_OK_IN), .GATE_ON_OUT(GATE_ON_OUT),
  .LOW_SUPPLY_NOTIFY_N_OUT(LOW_SUPPLY_NOTIFY_N_OUT),
  .LOW_SUPPLY_NOTIFY_N_OE_OUT(LOW_SUPPLY_NOTIFY_N_OE_OUT));
